// file: hw/soc_map.vh
`ifndef SOC_MAP_VH
`define SOC_MAP_VH
// ==========================================================
// timing
`define SOC_CLK_HZ          50000000
`define SOC_TICK_US         1
`define SOC_RESP_MIN_US     4200
`define SOC_RESP_MAX_US     6700
`define SOC_FING_MIN_US     5200
`define SOC_FING_MAX_US     43600
`define SOC_BLINK_MS        250
`define SOC_FB_CYC          16
`define SOC_SETTLE_CYC      2'h3
`define SOC_RANGE_SHORT_M   15
`define SOC_RANGE_LONG_M    50
// ==========================================================
// variants
`define SOC_VAR_FINGER      2'h0
`define SOC_VAR_HAND        2'h1
`define SOC_VAR_ACCESS      2'h2
// ==========================================================
// led colour codes {r,g,b}
`define SOC_LED_OFF         3'h0
`define SOC_LED_RED         3'h4
`define SOC_LED_GREEN       3'h2
`define SOC_LED_BLUE        3'h1
`define SOC_LED_PURPLE      3'h5
`define SOC_LED_YELLOW      3'h6
`define SOC_LED_ORANGE      3'h6
`endif

// file: hw/soc_safety_output_control.v
`timescale 1ns/1ps
`include "soc_map.vh"

module soc_safety_output_control #(
    parameter [1:0]  VARIANT   = `SOC_VAR_ACCESS,
    parameter        CLK_HZ    = `SOC_CLK_HZ,
    parameter        RESP_US   = `SOC_RESP_MIN_US,
    parameter        BLINK_MS  = `SOC_BLINK_MS
) (
    input  wire        clk_sys_i,
    input  wire        rst_i,
    input  wire        scan_done_i,
    input  wire        all_beams_ok_i,
    input  wire        lowest_beam_ok_i,
    input  wire        first_third_ok_i,
    input  wire        self_fault_i,
    input  wire        supply_polarity_i,
    input  wire        test_input_i,
    input  wire        range_sel_i,
    input  wire        range_wiring_fault_i,
    input  wire        fb_output_a_i,
    input  wire        fb_output_b_i,
    output reg         safety_output_a_o,
    output reg         safety_output_b_o,
    output reg         emit_enable_o,
    output reg         channel_o,
    output reg         long_range_o,
    output reg         output_fault_o,
    output reg  [2:0]  led_power_o,
    output reg  [2:0]  led_channel_o,
    output reg  [2:0]  led_status_o,
    output reg  [2:0]  led_mode_o,
    output reg  [2:0]  led_align_o
);

// ==========================================================
// timing
localparam integer RESP_CYC   = (CLK_HZ / 1000000) * RESP_US;
localparam integer BLINK_CYC  = (CLK_HZ / 1000) * BLINK_MS;
localparam integer FB_CYC     = `SOC_FB_CYC;
localparam integer RESP_W     = $clog2(RESP_CYC + 1);
localparam integer BLINK_W    = $clog2(BLINK_CYC + 1);

localparam [1:0] ST_OFF   = 2'h0;
localparam [1:0] ST_ON    = 2'h1;
localparam [1:0] ST_FAULT = 2'h2;

// ==========================================================
// pin synchronisers: three flops, change when 2nd and 3rd agree
reg  [2:0] s_pol;
reg  [2:0] s_test;
reg  [2:0] s_rng;
reg  [2:0] s_fba;
reg  [2:0] s_fbb;
reg        pol_q;
reg        test_q;
reg        rng_q;
reg        fba_q;
reg        fbb_q;

function agree_val;
    input [2:0] s;
    input       old;
    begin
        agree_val = (s[1] == s[2]) ? s[2] : old;
    end
endfunction

always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
        s_pol  <= 3'h0;
        s_test <= 3'h0;
        s_rng  <= 3'h0;
        s_fba  <= 3'h0;
        s_fbb  <= 3'h0;
        pol_q  <= 1'b0;
        test_q <= 1'b0;
        rng_q  <= 1'b0;
        fba_q  <= 1'b0;
        fbb_q  <= 1'b0;
    end else begin
        s_pol  <= {s_pol[1:0],  supply_polarity_i};
        s_test <= {s_test[1:0], test_input_i};
        s_rng  <= {s_rng[1:0],  range_sel_i};
        s_fba  <= {s_fba[1:0],  fb_output_a_i};
        s_fbb  <= {s_fbb[1:0],  fb_output_b_i};
        pol_q  <= agree_val(s_pol,  pol_q);
        test_q <= agree_val(s_test, test_q);
        rng_q  <= agree_val(s_rng,  rng_q);
        fba_q  <= agree_val(s_fba,  fba_q);
        fbb_q  <= agree_val(s_fbb,  fbb_q);
    end
end

// ==========================================================
// option outputs
always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
        channel_o     <= 1'b0;
        long_range_o  <= 1'b0;
        emit_enable_o <= 1'b0;
    end else begin
        channel_o     <= pol_q;
        long_range_o  <= (VARIANT == `SOC_VAR_ACCESS) & rng_q;
        // low or open test input stops emission, except in the access variant, which always emits
        emit_enable_o <= (VARIANT == `SOC_VAR_ACCESS) | test_q;
    end
end

// ==========================================================
// output feedback monitor
reg  [4:0]  fb_cnt;
wire        fb_mismatch;
wire        short_a;
wire        short_b;
wire        cross_short;
wire        cross_flag;

// a line reads back a level other than the one it is driven to
assign short_a     = (fba_q != safety_output_a_o);
assign short_b     = (fbb_q != safety_output_b_o);
// either line faulty drops both, so the healthy one goes off too
assign fb_mismatch = short_a | short_b;
// both on while commanded off on one side indicates bridging
assign cross_short = (fba_q & fbb_q) &
                     (safety_output_a_o ^ safety_output_b_o);
assign cross_flag  = cross_short;

always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
        fb_cnt         <= 5'h0;
        output_fault_o <= 1'b0;
    end else begin
        if (fb_mismatch | cross_flag) begin
            if (fb_cnt != FB_CYC[4:0])
                fb_cnt <= fb_cnt + 5'h1;
        end else begin
            fb_cnt <= 5'h0;
        end
        // held only while condition remains
        output_fault_o <= (fb_cnt == FB_CYC[4:0]);
    end
end

// ==========================================================
// start-up settle: pins need three edges before they mean anything
// outputs stay off until the synchronisers hold real pin levels
reg  [1:0]        settle_cnt;
wire              settled;

assign settled = (settle_cnt == `SOC_SETTLE_CYC);

always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i)
        settle_cnt <= 2'h0;
    else if (~settled)
        settle_cnt <= settle_cnt + 2'h1;
end

// ==========================================================
// scan watchdog: a scan missing for a response time stops the outputs
// a stalled scanner would otherwise leave the last verdict standing
reg  [RESP_W-1:0] scan_age;
wire              scan_stale;

// a scan in this very cycle refreshes the field, so it never counts stale
assign scan_stale = ~scan_done_i &
                    (scan_age == RESP_CYC[RESP_W-1:0]);

always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i)
        scan_age <= {RESP_W{1'b0}};
    else if (scan_done_i)
        scan_age <= {RESP_W{1'b0}};
    else if (scan_age != RESP_CYC[RESP_W-1:0])
        scan_age <= scan_age + {{(RESP_W-1){1'b0}}, 1'b1};
end

// ==========================================================
// output state machine
reg  [1:0]        state;
reg  [1:0]        next_state;
reg               clean_scan;
reg               split_fault;
wire              beam_stop;
wire              fault_stop;
wire              stop_req;

assign beam_stop  = ~all_beams_ok_i | scan_stale;
assign fault_stop = self_fault_i | split_fault | ~settled;
assign stop_req   = beam_stop | fault_stop;

always @* begin
    next_state = state;
    case (state)
        ST_OFF: begin
            if (output_fault_o)
                next_state = ST_FAULT;
            else if (scan_done_i & clean_scan & ~stop_req)
                next_state = ST_ON;
        end
        ST_ON: begin
            if (output_fault_o)
                next_state = ST_FAULT;
            else if (stop_req)
                next_state = ST_OFF;
        end
        ST_FAULT: begin
            if (~output_fault_o & (fb_cnt == 5'h0))
                next_state = ST_OFF;
        end
        default: next_state = ST_OFF;
    endcase
end

// clean_scan: a full scan finished with all beams and no fault
always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
        state      <= ST_OFF;
        clean_scan <= 1'b0;
    end else begin
        state <= next_state;
        if (stop_req | output_fault_o)
            clean_scan <= 1'b0;
        else if (scan_done_i)
            clean_scan <= 1'b1;
    end
end

// both outputs driven off together; off is reached one cycle after cause
// each output has its own register so one upset cannot hold both on
always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i)
        safety_output_a_o <= 1'b0;
    else
        safety_output_a_o <= (next_state == ST_ON);
end

always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i)
        safety_output_b_o <= 1'b0;
    else
        safety_output_b_o <= (next_state == ST_ON);
end

// the two channels disagreeing is an internal fault
always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i)
        split_fault <= 1'b0;
    else
        split_fault <= safety_output_a_o ^ safety_output_b_o;
end

// ==========================================================
// blink divider
reg  [BLINK_W-1:0] blink_cnt;
reg                blink;

always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
        blink_cnt <= {BLINK_W{1'b0}};
        blink     <= 1'b0;
    end else if (blink_cnt == BLINK_CYC[BLINK_W-1:0] - 1'b1) begin
        blink_cnt <= {BLINK_W{1'b0}};
        blink     <= ~blink;
    end else begin
        blink_cnt <= blink_cnt + {{(BLINK_W-1){1'b0}}, 1'b1};
    end
end

// ==========================================================
// indicators
reg  [2:0] next_align;
reg  [2:0] next_mode;

// alignment colour: off when aligned, blinking on partial, else steady
function [2:0] align_led;
    input all_ok;
    input part_ok;
    input blk;
    begin
        if (all_ok)
            align_led = `SOC_LED_OFF;
        else if (part_ok)
            align_led = blk ? `SOC_LED_ORANGE : `SOC_LED_OFF;
        else
            align_led = `SOC_LED_ORANGE;
    end
endfunction

always @* begin
    if (VARIANT == `SOC_VAR_ACCESS) begin
        next_align = align_led(all_beams_ok_i, lowest_beam_ok_i,
                               blink);
        if (range_wiring_fault_i)
            next_mode = `SOC_LED_RED;
        else if (rng_q)
            next_mode = `SOC_LED_BLUE;
        else
            next_mode = `SOC_LED_OFF;
    end else begin
        next_align = align_led(all_beams_ok_i, first_third_ok_i,
                               blink);
        next_mode = test_q ? `SOC_LED_OFF : `SOC_LED_YELLOW;
    end
end

always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
        led_power_o   <= `SOC_LED_GREEN;
        led_channel_o <= `SOC_LED_BLUE;
        led_status_o  <= `SOC_LED_RED;
        led_mode_o    <= `SOC_LED_OFF;
        led_align_o   <= `SOC_LED_ORANGE;
    end else begin
        led_power_o   <= `SOC_LED_GREEN;
        led_channel_o <= pol_q ? `SOC_LED_PURPLE : `SOC_LED_BLUE;
        led_status_o  <= safety_output_a_o ? `SOC_LED_GREEN
                                           : `SOC_LED_RED;
        led_mode_o    <= next_mode;
        led_align_o   <= next_align;
    end
end

endmodule // soc_safety_output_control

// file: test/soc_relay_model.sv
`timescale 1ns/1ps
// ==========================================================
// safety relay side: reads back both outputs, can short a to supply
module soc_relay_model (
    input  wire out_a_i,
    input  wire out_b_i,
    input  wire short_a_i,
    output wire fb_a_o,
    output wire fb_b_o
);
    assign fb_a_o = short_a_i ? 1'b1 : out_a_i;
    assign fb_b_o = out_b_i;
endmodule // soc_relay_model

// file: test/soc_chk_sva.sv
`timescale 1ns/1ps
// ==========================================================
// output checker
module soc_chk (
    input wire       clk_sys_i,
    input wire       rst_i,
    input wire       scan_done_i,
    input wire       all_beams_ok_i,
    input wire       lowest_beam_ok_i,
    input wire       self_fault_i,
    input wire       range_wiring_fault_i,
    input wire       safety_output_a_o,
    input wire       safety_output_b_o,
    input wire       output_fault_o,
    input wire       long_range_o,
    input wire       channel_o,
    input wire [2:0] led_power_o,
    input wire [2:0] led_channel_o,
    input wire [2:0] led_status_o,
    input wire [2:0] led_mode_o,
    input wire [2:0] led_align_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    sequence s_scan_ok;
        scan_done_i && all_beams_ok_i && !self_fault_i;
    endsequence
    sequence s_off;
        !safety_output_a_o && !safety_output_b_o;
    endsequence
    property p_on_cause;
        $rose(safety_output_a_o) |->
            $past(scan_done_i && all_beams_ok_i && !self_fault_i);
    endproperty
    property p_two_scans;
        s_scan_ok ##1 (s_scan_ok and (!output_fault_o)) |=>
            safety_output_a_o;
    endproperty
    property p_drop_beam;
        !all_beams_ok_i |=> s_off;
    endproperty
    property p_drop_fault;
        self_fault_i |=> s_off;
    endproperty
    property p_pair;
        safety_output_a_o == safety_output_b_o;
    endproperty
    property p_fault_hold;
        output_fault_o |=> s_off;
    endproperty
    property p_status;
        1'b1 |=> led_status_o ==
            ($past(safety_output_a_o) ? 3'h2 : 3'h4);
    endproperty
    property p_power;
        led_power_o == 3'h2;
    endproperty
    property p_ch_led;
        $stable(channel_o) [*2] |->
            led_channel_o == (channel_o ? 3'h5 : 3'h1);
    endproperty
    property p_mode_led;
        ($stable(long_range_o) && $stable(range_wiring_fault_i)) [*2] |->
            led_mode_o == (range_wiring_fault_i ? 3'h4 :
                           long_range_o ? 3'h1 : 3'h0);
    endproperty
    property p_align_on;
        (!all_beams_ok_i && !lowest_beam_ok_i) |=> led_align_o == 3'h6;
    endproperty
    property p_align_off;
        all_beams_ok_i |=> led_align_o == 3'h0;
    endproperty
    a_on_cause:   assert property (p_on_cause)   else $error("on w/o scan");
    a_two_scans:  assert property (p_two_scans)  else $error("no turn-on");
    a_drop_beam:  assert property (p_drop_beam)  else $error("beam drop");
    a_drop_fault: assert property (p_drop_fault) else $error("fault drop");
    a_pair:       assert property (p_pair)       else $error("a b differ");
    a_fault_hold: assert property (p_fault_hold) else $error("fault on");
    a_status:     assert property (p_status)     else $error("status led");
    a_power:      assert property (p_power)      else $error("power led");
    a_ch_led:     assert property (p_ch_led)     else $error("chan led");
    a_mode_led:   assert property (p_mode_led)   else $error("mode led");
    a_align_on:   assert property (p_align_on)   else $error("align on");
    a_align_off:  assert property (p_align_off)  else $error("align off");
endmodule // soc_chk
bind soc_safety_output_control soc_chk i_chk (.clk_sys_i, .rst_i,
    .scan_done_i, .all_beams_ok_i, .lowest_beam_ok_i, .self_fault_i,
    .range_wiring_fault_i,
    .safety_output_a_o, .safety_output_b_o, .output_fault_o,
    .long_range_o, .channel_o, .led_power_o, .led_channel_o,
    .led_status_o, .led_mode_o, .led_align_o);

// file: test/soc_safety_output_control_tb.sv
`timescale 1ns/1ps
// ==========================================================
// testbench
module soc_safety_output_control_tb;
    reg        clk_sys_i = 0, rst_i = 1, scan_i = 0, ok_i = 0, sf_i = 0;
    reg        low_i = 0, third_i = 0, pol_i = 0, test_i = 1, rng_i = 0;
    reg        wf_i = 0, short_a = 0;
    wire       fb_a, fb_b, out_a, out_b, emit, chan, lrng, ofault;
    wire [2:0] l_pw, l_ch, l_st, l_md, l_al;
    int        err_count = 0;
    int        tests_run = 0;
    logic [5:0] q[$];
    event      ev;
    initial forever #10 clk_sys_i = ~clk_sys_i;
    soc_safety_output_control #(.BLINK_MS(1)) i_dut (.clk_sys_i, .rst_i,
        .scan_done_i(scan_i), .all_beams_ok_i(ok_i), .lowest_beam_ok_i(low_i),
        .first_third_ok_i(third_i), .self_fault_i(sf_i),
        .supply_polarity_i(pol_i), .test_input_i(test_i),
        .range_sel_i(rng_i), .range_wiring_fault_i(wf_i),
        .fb_output_a_i(fb_a), .fb_output_b_i(fb_b),
        .safety_output_a_o(out_a), .safety_output_b_o(out_b),
        .emit_enable_o(emit), .channel_o(chan), .long_range_o(lrng),
        .output_fault_o(ofault), .led_power_o(l_pw), .led_channel_o(l_ch),
        .led_status_o(l_st), .led_mode_o(l_md), .led_align_o(l_al));
    soc_relay_model i_relay (.out_a_i(out_a), .out_b_i(out_b),
        .short_a_i(short_a), .fb_a_o(fb_a), .fb_b_o(fb_b));
    always @(posedge clk_sys_i) #2 {low_i, third_i} = $urandom;
    task cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
        #2;
    endtask
    task chk(input [2:0] id, input [2:0] e);
        q.push_back({id, e});
        ->ev;
    endtask
    function [2:0] obs(input [2:0] id);
        case (id)
            0: obs = {1'b0, out_a, out_b};
            1: obs = l_st;
            2: obs = l_pw;
            3: obs = {2'b0, ofault};
            4: obs = l_ch;
            5: obs = l_md;
            6: obs = {1'b0, chan, lrng};
            default: obs = {2'b0, emit};
        endcase
    endfunction
    task check(input [2:0] s, input [2:0] e);
        tests_run++;
        if (s !== e) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task final_report;
        $display("tests_run %0d err_count %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task scan2;
        ok_i = 1;
        scan_i = 1;
        cyc(2);
        scan_i = 0;
    endtask
    // ==========================================================
    // monitor: compares every queued note, oldest first, against the outputs
    initial forever begin
        @ev;
        while (q.size() > 0) begin
            check(obs(q[0][5:3]), q[0][2:0]);
            void'(q.pop_front());
        end
    end
    initial begin
        #20000;
        err_count++;
        final_report;
    end
    // ==========================================================
    // stimulus
    initial begin
        void'($urandom(69827));
        cyc(2);
        chk(0, 3'h0);
        chk(2, 3'h2);
        chk(1, 3'h4);
        chk(4, 3'h1);
        rst_i = 0;
        cyc(4);
        ok_i = 1;
        scan_i = 1;
        cyc(1);
        scan_i = 0;
        cyc(3);
        chk(0, 3'h0);
        scan2;
        chk(0, 3'h3);
        cyc(1);
        chk(1, 3'h2);
        ok_i = 0;
        cyc(1);
        chk(0, 3'h0);
        cyc(1);
        chk(1, 3'h4);
        scan2;
        sf_i = 1;
        cyc(1);
        sf_i = 0;
        chk(0, 3'h0);
        scan2;
        short_a = 1;
        ok_i = 0;
        cyc(30);
        chk(3, 3'h1);
        scan2;
        chk(0, 3'h0);
        short_a = 0;
        cyc(30);
        chk(3, 3'h0);
        scan2;
        chk(0, 3'h3);
        pol_i = 1;
        rng_i = $urandom % 2;
        test_i = 0;
        cyc(8);
        chk(6, {1'b0, 1'b1, rng_i});
        chk(4, 3'h5);
        chk(5, rng_i ? 3'h1 : 3'h0);
        chk(7, 3'h1);
        wf_i = 1;
        cyc(4);
        chk(5, 3'h4);
        cyc(2);
        final_report;
    end
endmodule // soc_safety_output_control_tb
